// >>> src/ebh_consts.vh
// constants for the external bus handover block
`ifndef EBH_CONSTS_VH
`define EBH_CONSTS_VH
`define EBH_NUM_SELECTS      5
`define EBH_SEL_PROGRAM      0
`define EBH_SEL_DATA         1
`define EBH_SEL_COMPOSITE    2
`define EBH_SEL_IO           3
`define EBH_SEL_BYTE         4
`define EBH_SELECT_IDLE      5'h1f
`define EBH_CYCLE_DIV_HALF   1
`define EBH_SYNC_STAGES      2
`endif

// >>> src/ebh_cycle_clock.v
// divider producing the processor cycle clock output and its rising-edge tick
`timescale 1ns/1ns
module ebh_cycle_clock (
   input  wire clk,                  // system clock
   input  wire rst_n,                // synchronous reset, active low
   input  wire ce,                   // clock enable
   output reg  cycle_clock_output,   // processor cycle clock pin
   output reg  cycle_rise            // one-clk pulse when the pin goes high
);
   // clk stands in for the doubled input clock; the pin toggles every clk
   always @(posedge clk) begin
      if (!rst_n) begin
         cycle_clock_output <= 1'b0;
         cycle_rise         <= 1'b0;
      end else if (ce) begin
         cycle_clock_output <= ~cycle_clock_output;
         cycle_rise         <= ~cycle_clock_output;
      end
   end
endmodule // ebh_cycle_clock

// >>> src/ebh_bus_handover.v
// bus handover arbiter: request sync, strobe float, grant and grant-hung
`timescale 1ns/1ns
`include "ebh_consts.vh"
//
// Contract
// - async request sampled through two flops, acted on that or next cycle
// - strobes float before grant goes low
// - grant returns high before strobes are driven again
// - grant-hung low while granted and core or byte engine wants bus
// - grant-hung never low before strobes are floated
// - grant-hung high before strobes are driven again
// - processor cycle runs at half the clk rate
module ebh_bus_handover (
   input  wire                         clk,                       // system clock
   input  wire                         rst_n,                     // synchronous reset, active low
   input  wire                         ce,                        // clock enable, freezes state
   input  wire                         bus_request_n,             // async request from outside master
   input  wire                         core_bus_need,             // core wants the external bus
   input  wire                         byte_engine_bus_need,      // byte transfer engine wants the bus
   input  wire [`EBH_NUM_SELECTS-1:0]  select_n_in,               // core's select strobes
   input  wire                         rd_n_in,                   // core's read strobe
   input  wire                         wr_n_in,                   // core's write strobe
   output reg  [`EBH_NUM_SELECTS-1:0]  memory_select_strobes,     // select strobes out
   output reg  [`EBH_NUM_SELECTS-1:0]  memory_select_strobes_oe_n,// select enables, low drives
   output reg                          rd_n,                      // read strobe out
   output reg                          rd_oe_n,                   // read enable, low drives
   output reg                          wr_n,                      // write strobe out
   output reg                          wr_oe_n,                   // write enable, low drives
   output reg                          bus_grant_n,               // grant to outside master
   output reg                          grant_hung_n,              // grant-hung indication
   output reg                          granted,                   // status: bus given away
   output wire                         cycle_clock_output         // processor cycle clock
);
   localparam [3:0] ST_OWN     = 4'b0001;
   localparam [3:0] ST_FLOAT   = 4'b0010;
   localparam [3:0] ST_GRANT   = 4'b0100;
   localparam [3:0] ST_RELEASE = 4'b1000;

   reg [3:0] state_r;
   reg [3:0] state_nxt;
   reg       req_meta_r;
   reg       req_sync_r;
   wire      cycle_rise;
   wire      need = core_bus_need | byte_engine_bus_need;

   ebh_cycle_clock u_cyc (
      .clk                (clk),
      .rst_n              (rst_n),
      .ce                 (ce),
      .cycle_clock_output (cycle_clock_output),
      .cycle_rise         (cycle_rise)
   );

   // first flop is read only by the second
   always @(posedge clk) begin
      if (!rst_n) begin
         req_meta_r <= 1'b1;
         req_sync_r <= 1'b1;
      end else if (ce) begin
         req_meta_r <= bus_request_n;
         req_sync_r <= req_meta_r;
      end
   end

   // decisions only on cycle clock rise, so request taken per processor cycle
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_OWN:     if (cycle_rise && !req_sync_r) state_nxt = ST_FLOAT;
         ST_FLOAT:   state_nxt = ST_GRANT;
         ST_GRANT:   if (cycle_rise && req_sync_r) state_nxt = ST_RELEASE;
         ST_RELEASE: state_nxt = ST_OWN;
         default:    state_nxt = ST_OWN;
      endcase
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         state_r                    <= ST_OWN;
         memory_select_strobes      <= `EBH_SELECT_IDLE;
         memory_select_strobes_oe_n <= {`EBH_NUM_SELECTS{1'b0}};
         rd_n                       <= 1'b1;
         rd_oe_n                    <= 1'b0;
         wr_n                       <= 1'b1;
         wr_oe_n                    <= 1'b0;
         bus_grant_n                <= 1'b1;
         grant_hung_n               <= 1'b1;
         granted                    <= 1'b0;
      end else if (ce) begin
         state_r <= state_nxt;
         // strobes follow the core only while owning the bus
         if (state_nxt == ST_OWN) begin
            memory_select_strobes      <= select_n_in;
            memory_select_strobes_oe_n <= {`EBH_NUM_SELECTS{1'b0}};
            rd_n                       <= rd_n_in;
            rd_oe_n                    <= 1'b0;
            wr_n                       <= wr_n_in;
            wr_oe_n                    <= 1'b0;
         end else begin
            // park high on the same edge as floating so pullups see no glitch
            memory_select_strobes      <= `EBH_SELECT_IDLE;
            memory_select_strobes_oe_n <= {`EBH_NUM_SELECTS{1'b1}};
            rd_n                       <= 1'b1;
            rd_oe_n                    <= 1'b1;
            wr_n                       <= 1'b1;
            wr_oe_n                    <= 1'b1;
         end
         // grant and hung only in ST_GRANT, a cycle after float and before drive
         bus_grant_n  <= (state_nxt != ST_GRANT) || (state_r != ST_GRANT && state_r != ST_FLOAT);
         grant_hung_n <= !(state_nxt == ST_GRANT && state_r != ST_OWN && need);
         granted      <= (state_nxt != ST_OWN);
      end
   end
endmodule // ebh_bus_handover

// >>> sim/ebh_bus_handover_monitor.sv
// assertion checker for the bus handover arbiter
`timescale 1ns/1ns
`include "ebh_consts.vh"
module ebh_bus_handover_monitor (
   input wire clk, rst_n, bus_request_n, core_bus_need, byte_engine_bus_need, rd_oe_n, wr_oe_n,
   input wire [`EBH_NUM_SELECTS-1:0] memory_select_strobes_oe_n,
   input wire bus_grant_n, grant_hung_n, cycle_clock_output
);
   wire fl = rd_oe_n && wr_oe_n && (&memory_select_strobes_oe_n);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_lat; $fell(bus_request_n) |-> ##[3:5] !bus_grant_n; endproperty
   a_lat: assert property (p_lat) else $error("grant late");
   property p_flt; $fell(bus_grant_n) |-> fl; endproperty
   a_flt: assert property (p_flt) else $error("grant before float");
   property p_drv; !rd_oe_n |-> bus_grant_n && grant_hung_n; endproperty
   a_drv: assert property (p_drv) else $error("driving while granted");
   property p_ret; $rose(bus_grant_n) |=> !rd_oe_n && !wr_oe_n; endproperty
   a_ret: assert property (p_ret) else $error("strobes not back");
   property p_hng; $past(!bus_grant_n) && !bus_grant_n |-> grant_hung_n == !$past(core_bus_need || byte_engine_bus_need); endproperty
   a_hng: assert property (p_hng) else $error("hung wrong");
   property p_hfl; !grant_hung_n |-> fl; endproperty
   a_hfl: assert property (p_hfl) else $error("hung before float");
   property p_clk; 1'b1 |=> cycle_clock_output != $past(cycle_clock_output); endproperty
   a_clk: assert property (p_clk) else $error("cycle clock stuck");
   property p_hld; !bus_grant_n && !bus_request_n |=> !bus_grant_n; endproperty
   a_hld: assert property (p_hld) else $error("grant dropped");
endmodule // ebh_bus_handover_monitor
bind ebh_bus_handover ebh_bus_handover_monitor mon (.clk(clk), .rst_n(rst_n), .bus_request_n(bus_request_n),
   .core_bus_need(core_bus_need), .byte_engine_bus_need(byte_engine_bus_need), .rd_oe_n(rd_oe_n),
   .wr_oe_n(wr_oe_n), .memory_select_strobes_oe_n(memory_select_strobes_oe_n), .bus_grant_n(bus_grant_n),
   .grant_hung_n(grant_hung_n), .cycle_clock_output(cycle_clock_output));

// >>> sim/ebh_master_model.sv
// outside bus master model driving the request
`timescale 1ns/1ns
module ebh_master_model (
   input wire clk, go, bus_grant_n,
   input wire [3:0] hold,
   output reg bus_request_n
);
   reg [3:0] cnt_r;
   initial begin
      bus_request_n = 1'b1;
      cnt_r = 4'h0;
   end
   always @(posedge clk) begin
      if (bus_request_n && go) bus_request_n <= 1'b0;
      else if (!bus_request_n && !bus_grant_n) begin
         cnt_r <= (cnt_r == hold) ? 4'h0 : cnt_r + 4'h1;
         if (cnt_r == hold) bus_request_n <= 1'b1;
      end
   end
endmodule // ebh_master_model

// >>> sim/testbench.sv
// self-checking bench for the bus handover arbiter
`timescale 1ns/1ns
module testbench;
   reg clk, rst_n, go, cn, bn, ri, wi, need_q, run_q, ck_q;
   reg [6:0] core_q;
   reg [31:0] rnd_a, rnd_b;
   reg [4:0] sel;
   reg [3:0] hold;
   wire req_n, rd, ro, wr, wo, bg, gh, gr, ck;
   wire [4:0] ms, mo;
   integer seed, miscompares, num_checks, cyc, n, t;
   ebh_bus_handover dut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .bus_request_n(req_n), .core_bus_need(cn),
      .byte_engine_bus_need(bn), .select_n_in(sel), .rd_n_in(ri), .wr_n_in(wi), .memory_select_strobes(ms),
      .memory_select_strobes_oe_n(mo), .rd_n(rd), .rd_oe_n(ro), .wr_n(wr), .wr_oe_n(wo), .bus_grant_n(bg),
      .grant_hung_n(gh), .granted(gr), .cycle_clock_output(ck));
   ebh_master_model mst (.clk(clk), .go(go), .bus_grant_n(bg), .hold(hold), .bus_request_n(req_n));
   initial begin clk = 1'b0; forever #50 clk = ~clk; end
   function hung_exp(input need); hung_exp = ~need; endfunction
   task chk(input [39:0] nm, input [7:0] e, input [7:0] g);
      begin
         num_checks = num_checks + 1;
         if (g !== e) begin miscompares = miscompares + 1; $display("wrong value %s exp %h got %h", nm, e, g); end
      end
   endtask
   task results;
      begin
         $display("checks %0d mismatches %0d", num_checks, miscompares);
         if (miscompares == 0 && num_checks > 0) $display("DONE - PASS");
         else $display("DONE - FAIL");
         $finish;
      end
   endtask
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 3000) begin miscompares = miscompares + 1; results; end
      need_q <= cn | bn;
      run_q <= rst_n;
      core_q <= {ri, wi, sel};
      rnd_a = $random(seed);
      {cn, bn, ri, wi, sel} <= rnd_a[8:0];
   end
   always @(negedge clk) begin
      if (rst_n) begin
         if (!bg && gr) chk("hung", {7'h0, hung_exp(need_q)}, {7'h0, gh});
         if (ro) chk("park", 8'h7f, {1'b0, rd, wr, ms});
      end
      if (run_q) begin
         if (!ro) chk("own", {1'b0, core_q}, {1'b0, rd, wr, ms});
         chk("oe", ro ? 8'hff : 8'h00, {gr, wo, ro, mo});
         if (!gh) chk("hfl", 8'h01, {7'h0, ro});
         if (!ro) chk("hdrv", 8'h03, {6'h0, bg, gh});
         chk("clk", {7'h0, ~ck_q}, {7'h0, ck});
      end
      ck_q = ck;
   end
   initial begin
      seed = 81; miscompares = 0; num_checks = 0; cyc = 0; rst_n = 1'b0; go = 1'b0; hold = 4'h0;
      cn = 1'b0; bn = 1'b0; ri = 1'b1; wi = 1'b1; sel = 5'h1f; need_q = 1'b0;
      run_q = 1'b0; ck_q = 1'b0; core_q = 7'h7f;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk) chk("rst", 8'h06, {5'h0, bg, gh, gr});
      for (t = 0; t < 24; t = t + 1) begin
         @(posedge clk) rnd_b = $random(seed);
         hold <= (t == 0) ? 4'h0 : (t == 1) ? 4'hf : rnd_b[3:0];
         go <= 1'b1;
         @(posedge clk) go <= 1'b0;
         n = 0;
         @(negedge clk) while (bg !== 1'b0 && n < 20) begin n = n + 1; @(negedge clk); end
         chk("lat", 8'h01, {7'h0, n >= 3 && n <= 5});
         n = 0;
         while (bg !== 1'b1 && n < 40) begin n = n + 1; @(negedge clk); end
         chk("held", 8'h01, {7'h0, n > hold && bg === 1'b1});
         repeat (4) @(posedge clk);
      end
      results;
   end
endmodule // testbench
